//--- cwd_pkg.sv
// Purpose: Shared constants and types for the configuration word decoder
// Assumes: 14-bit configuration word, active-low programmed bits
// Notes: Bit positions, reset values and oscillator codes live here only
package cwd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Word geometry
  localparam int CWD_WORD_W = 14;                              // Width of the configuration word
  localparam logic [13:0] CWD_WORD_ADDR = 14'h2007;            // Location of the word in test space
  localparam logic [13:0] CWD_TEST_BASE = 14'h2000;            // First address of test/config space
  localparam logic [13:0] CWD_ERASED = 14'h3fff;               // Unprogrammed word, every bit reads 1
  localparam logic [13:0] CWD_ZERO = 14'h0000;                 // Answer outside the word itself

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CWD_CP_HI_A = 13;                             // Flash protect field, upper copy
  localparam int CWD_CP_LO_A = 12;
  localparam int CWD_DEBUG_DIS = 11;                           // 1 = debugger off
  localparam int CWD_UNIMPL = 10;                              // Unimplemented, reads 1
  localparam int CWD_WRT_EN = 9;                               // Flash self-write enable
  localparam int CWD_DATA_CP_N = 8;                            // 0 = data memory protected
  localparam int CWD_LOW_VOLT_PROG_EN = 7;                     // Low-voltage programming enable
  localparam int CWD_BROWNOUT_EN = 6;                          // Brown-out reset enable
  localparam int CWD_CP_HI_B = 5;                              // Flash protect field, lower copy
  localparam int CWD_CP_LO_B = 4;
  localparam int CWD_PUD_EN_N = 3;                             // 0 = power-up delay enabled
  localparam int CWD_WATCHDOG_EN = 2;                          // Watchdog enable
  localparam int CWD_OSC_HI = 1;                               // Clock source select
  localparam int CWD_OSC_LO = 0;

  ////////////////////////////////////////////////////////////////////////
  // Field codes
  localparam logic [1:0] CWD_CP_OFF = 2'h3;                    // Protection off
  localparam logic [1:0] CWD_CP_ON = 2'h0;                     // Protection on
  localparam logic [1:0] CWD_OSC_RES_CAP = 2'h3;               // Resistor-capacitor
  localparam logic [1:0] CWD_OSC_FAST_XTAL = 2'h2;             // High-speed crystal
  localparam logic [1:0] CWD_OSC_STD_XTAL = 2'h1;              // Standard crystal/resonator
  localparam logic [1:0] CWD_OSC_LOW_PWR = 2'h0;               // Low-power crystal
  localparam logic [10:0] CWD_STARTUP_CYCLES = 11'h400;        // Oscillator start-up delay, 1024 cycles
  localparam logic [10:0] CWD_STARTUP_NONE = 11'h000;          // No start-up delay

  // One-hot oscillator mode index
  localparam int CWD_MODE_LOW_PWR = 0;
  localparam int CWD_MODE_STD_XTAL = 1;
  localparam int CWD_MODE_FAST_XTAL = 2;
  localparam int CWD_MODE_RES_CAP = 3;

  // Loader states, one-hot
  typedef enum logic [1:0] {
    CWD_LOAD = 2'b01,
    CWD_RUN = 2'b10
  } cwd_state_t;

  // True for the three crystal modes
  function automatic logic cwd_is_crystal(input logic [1:0] sel);
    cwd_is_crystal = (sel != CWD_OSC_RES_CAP);
  endfunction

endpackage

//--- cwd_osc_decode.sv
// Purpose: Oscillator mode decode from the two clock source select bits
// Assumes: Select bits come from a held configuration register
// Notes: Purely combinational, no state
`timescale 1ns/10ps
module cwd_osc_decode (
  input wire logic [1:0] clock_source_sel,
  output logic [3:0] osc_mode,
  output logic crystal_mode
);
  import cwd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Two bits alone choose one of four modes, every code is legal
  always_comb begin
    osc_mode = 4'h0;
    case (clock_source_sel)                                    // RULE7
      CWD_OSC_RES_CAP: osc_mode[CWD_MODE_RES_CAP] = 1'b1;      // RULE6
      CWD_OSC_FAST_XTAL: osc_mode[CWD_MODE_FAST_XTAL] = 1'b1;  // RULE6
      CWD_OSC_STD_XTAL: osc_mode[CWD_MODE_STD_XTAL] = 1'b1;    // RULE6
      default: osc_mode[CWD_MODE_LOW_PWR] = 1'b1;              // RULE6
    endcase
    crystal_mode = cwd_is_crystal(clock_source_sel);
  end

endmodule // cwd_osc_decode

//--- cwd_config_word_decoder.sv
// Purpose: Capture the configuration word at reset and decode it into settings
// Assumes: nv_config_word is stable from the array while rst_b is low and after
// Notes: Settings only change across a reset; the word reads back in programming mode
//
// Summary of operation
// RULE1: Flash protect 11 off, 00 on
// RULE2: Low-voltage bit selects programming pin function
// RULE3: Bit 6 enables brown-out reset
// RULE4: Bit 3 low enables power-up delay
// RULE5: Bit 2 enables the watchdog
// RULE6: Bits 1:0 select RC, HS, XT, LP
// RULE7: Exactly four modes, two bits only
// RULE8: Crystal modes accept external clock input
// RULE9: Word at 2007h, readable only programming
// RULE10: Programmed bit reads 0, unprogrammed 1
// RULE11: Brown-out enable forces power-up delay on
// RULE12: Start-up delay: crystal modes, power-on/wake only
// RULE13: Bit 11 releases or claims debug pins
// RULE14: Sample at reset, hold, bit 10 reads 1
`timescale 1ns/10ps
module cwd_config_word_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] nv_config_word,
  input wire logic prog_mode,
  input wire logic cfg_rd,
  input wire logic [13:0] cfg_addr,
  input wire logic por_event,
  input wire logic wake_event,
  output logic [cwd_pkg::CWD_WORD_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic settings_valid,
  output logic flash_protect_on,
  output logic flash_protect_unsupported,
  output logic flash_write_enable,
  output logic data_protect_on,
  output logic debugger_enable,
  output logic debug_pins_io,
  output logic prog_pin_is_pgm,
  output logic hv_prog_required,
  output logic brownout_reset_enable,
  output logic power_up_delay_on,
  output logic watchdog_enable,
  output logic [3:0] osc_mode,
  output logic ext_clock_allowed,
  output logic osc_startup_req,
  output logic [10:0] osc_startup_cycles
);
  import cwd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    cwd_state_t state;                                         // Loader state
    logic [CWD_WORD_W-1:0] word;                               // Held configuration word
    logic [CWD_WORD_W-1:0] rdata;                              // Read-back data
    logic rvalid;                                              // Read-back strobe
    logic startup_req;                                         // Start-up delay request
    logic [10:0] startup_cycles;                               // Start-up delay length
  } cwd_regs_t;

  cwd_regs_t st;                                               // Registered state
  cwd_regs_t next_st;                                          // Next state
  logic crystal;                                               // Any crystal mode
  logic [1:0] cp_a;                                            // Upper protect copy
  logic [1:0] cp_b;                                            // Lower protect copy
  logic in_test_space;                                         // Address in config space

  ////////////////////////////////////////////////////////////////////////
  // Oscillator decode
  cwd_osc_decode u_osc (
    .clock_source_sel({st.word[CWD_OSC_HI], st.word[CWD_OSC_LO]}),
    .osc_mode(osc_mode),
    .crystal_mode(crystal)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    cp_a = {st.word[CWD_CP_HI_A], st.word[CWD_CP_LO_A]};
    cp_b = {st.word[CWD_CP_HI_B], st.word[CWD_CP_LO_B]};
    in_test_space = (cfg_addr >= CWD_TEST_BASE);
    case (st.state)
      CWD_LOAD: begin
        // First edge after release takes the word, never inside reset
        next_st.word = nv_config_word;                         // RULE14
        next_st.word[CWD_UNIMPL] = 1'b1;                       // RULE14
        next_st.state = CWD_RUN;
      end
      CWD_RUN: begin
        // Word held; only a new reset re-samples it
        next_st.state = CWD_RUN;                               // RULE14
      end
      default: begin
        next_st.state = CWD_LOAD;
      end
    endcase
    // Test space answers only in programming mode; a read elsewhere is ignored
    if (cfg_rd && prog_mode && in_test_space) begin            // RULE9
      next_st.rvalid = 1'b1;
      if (cfg_addr == CWD_WORD_ADDR) begin
        next_st.rdata = st.word;                               // RULE9
      end else begin
        next_st.rdata = CWD_ZERO;
      end
    end
    // Start-up delay only for crystals, and only on power-on or wake
    // One cycle per qualifying cycle; the timer elsewhere latches the request
    if (st.state == CWD_RUN && crystal && (por_event || wake_event)) begin // RULE12
      next_st.startup_req = 1'b1;
      next_st.startup_cycles = CWD_STARTUP_CYCLES;             // RULE12
    end else begin
      next_st.startup_req = 1'b0;
      next_st.startup_cycles = CWD_STARTUP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset loads the erased word as a safe default
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.state <= CWD_LOAD;
      st.word <= CWD_ERASED;
      st.rdata <= CWD_ZERO;
      st.rvalid <= 1'b0;
      st.startup_req <= 1'b0;
      st.startup_cycles <= CWD_STARTUP_NONE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded settings from the held word; valid flag, read-back and start-up request from their own registers
  assign settings_valid = (st.state == CWD_RUN);
  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  // Both copies must agree; mixed codes flag as unsupported and stay protected
  assign flash_protect_unsupported = (cp_a != cp_b) ||
                                     ((cp_a != CWD_CP_OFF) && (cp_a != CWD_CP_ON)); // RULE1
  assign flash_protect_on = !((cp_a == CWD_CP_OFF) && (cp_b == CWD_CP_OFF)); // RULE1
  assign flash_write_enable = st.word[CWD_WRT_EN];
  assign data_protect_on = !st.word[CWD_DATA_CP_N];            // RULE10
  assign debugger_enable = !st.word[CWD_DEBUG_DIS];            // RULE13
  assign debug_pins_io = st.word[CWD_DEBUG_DIS];               // RULE13
  assign prog_pin_is_pgm = st.word[CWD_LOW_VOLT_PROG_EN];      // RULE2
  assign hv_prog_required = !st.word[CWD_LOW_VOLT_PROG_EN];    // RULE2
  assign brownout_reset_enable = st.word[CWD_BROWNOUT_EN];     // RULE3
  // Brown-out enable overrides the delay bit
  assign power_up_delay_on = !st.word[CWD_PUD_EN_N] || st.word[CWD_BROWNOUT_EN]; // RULE4 RULE11 RULE10
  assign watchdog_enable = st.word[CWD_WATCHDOG_EN];           // RULE5
  assign ext_clock_allowed = crystal;                          // RULE8
  assign osc_startup_req = st.startup_req;
  assign osc_startup_cycles = st.startup_cycles;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_word_held: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    $past(settings_valid) |-> $stable(st.word))
    else $error("config word changed while running");
  a_unimpl_one: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    settings_valid |-> st.word[CWD_UNIMPL])
    else $error("unimplemented bit not one");
  a_load_once: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    !settings_valid |=> settings_valid)
    else $error("word not captured after release");
  a_read_gated: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    cfg_rvalid |-> $past(prog_mode) && $past(cfg_rd))
    else $error("config read answered outside programming mode");
  a_read_word: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    (cfg_rd && prog_mode && cfg_addr == CWD_WORD_ADDR) |=> cfg_rvalid && cfg_rdata == $past(st.word))
    else $error("config word read wrong");
  a_pud_forced: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    brownout_reset_enable |-> power_up_delay_on)
    else $error("brown-out did not force power-up delay");
  a_pud_polarity: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    !brownout_reset_enable |-> (power_up_delay_on == !st.word[CWD_PUD_EN_N]))
    else $error("power-up delay polarity wrong");
  a_startup_crystal: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    osc_startup_req |-> !osc_mode[CWD_MODE_RES_CAP] && osc_startup_cycles == CWD_STARTUP_CYCLES)
    else $error("start-up delay outside crystal mode");
  a_startup_cause: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    (settings_valid && crystal && por_event) |=> osc_startup_req)
    else $error("start-up delay not requested");
  a_startup_wake: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    (settings_valid && crystal && wake_event) |=> osc_startup_req)
    else $error("start-up delay not requested on wake");
  // A request with no power-on or wake behind it would stall the core for nothing
  a_startup_only: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    osc_startup_req |-> $past(settings_valid) && ($past(por_event) || $past(wake_event)))
    else $error("start-up delay without a cause");
  a_mode_onehot: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    $onehot(osc_mode) && (osc_mode[CWD_MODE_RES_CAP] == (st.word[CWD_OSC_HI] && st.word[CWD_OSC_LO])))
    else $error("oscillator mode not one of four");
  a_cp_on: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    (settings_valid && cp_a == CWD_CP_ON && cp_b == CWD_CP_ON) |-> flash_protect_on && !flash_protect_unsupported)
    else $error("protection decode wrong");
  a_prog_pin: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    prog_pin_is_pgm != hv_prog_required)
    else $error("programming pin function inconsistent");
  a_read_space: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    cfg_rvalid |-> $past(cfg_addr) >= CWD_TEST_BASE)
    else $error("read answered below test space");
  a_unimpl_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    (cfg_rvalid && $past(cfg_addr) == CWD_WORD_ADDR) |-> cfg_rdata[CWD_UNIMPL])
    else $error("unimplemented bit read back as zero");

  ////////////////////////////////////////////////////////////////////////
  // Settings against the raw word as it stood on the capture edge;
  // these catch a wrong bit position that the held-word checks cannot see
  a_capture_protect: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    $rose(settings_valid) |-> flash_protect_on == !($past(nv_config_word[CWD_CP_HI_A]) &&
      $past(nv_config_word[CWD_CP_LO_A]) && $past(nv_config_word[CWD_CP_HI_B]) &&
      $past(nv_config_word[CWD_CP_LO_B])))
    else $error("protection not taken from the captured word");
  a_capture_prog_pin: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    $rose(settings_valid) |-> prog_pin_is_pgm == $past(nv_config_word[CWD_LOW_VOLT_PROG_EN]))
    else $error("programming pin not taken from the captured word");
  a_capture_brownout: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    $rose(settings_valid) |-> brownout_reset_enable == $past(nv_config_word[CWD_BROWNOUT_EN]))
    else $error("brown-out enable not taken from the captured word");
  a_capture_delay: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    ($rose(settings_valid) && !brownout_reset_enable) |->
      power_up_delay_on == !$past(nv_config_word[CWD_PUD_EN_N]))
    else $error("power-up delay not taken from the captured word");
  a_capture_watchdog: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    $rose(settings_valid) |-> watchdog_enable == $past(nv_config_word[CWD_WATCHDOG_EN]))
    else $error("watchdog enable not taken from the captured word");
  a_capture_clock: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    $rose(settings_valid) |-> osc_mode[CWD_MODE_FAST_XTAL] ==
      ($past(nv_config_word[CWD_OSC_HI]) && !$past(nv_config_word[CWD_OSC_LO])))
    else $error("clock source select decoded wrong");
  a_capture_ext_clock: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    $rose(settings_valid) |->
      ext_clock_allowed == !($past(nv_config_word[CWD_OSC_HI]) && $past(nv_config_word[CWD_OSC_LO])))
    else $error("external clock permission wrong");
  a_capture_debug: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    $rose(settings_valid) |-> debug_pins_io == $past(nv_config_word[CWD_DEBUG_DIS]) && debugger_enable != debug_pins_io)
    else $error("debug pin ownership wrong");
  a_capture_data_prot: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
    $rose(settings_valid) |-> data_protect_on == !$past(nv_config_word[CWD_DATA_CP_N]))
    else $error("data protection polarity wrong");

endmodule // cwd_config_word_decoder

//--- cwd_programmer_model.sv
// Purpose: Behavioural model of the external programmer that owns the configuration word
// Assumes: Bench issues erase and program strobes away from the capture edge
// Notes: Programming can only clear bits; only an erase brings bits back to 1
`timescale 1ns/10ps
module cwd_programmer_model (
  input wire logic clk,
  input wire logic erase_go,
  input wire logic prog_go,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] prog_word,
  output logic [cwd_pkg::CWD_WORD_W-1:0] nv_config_word
);
  import cwd_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Array starts erased, every bit unprogrammed
  initial nv_config_word = CWD_ERASED;
  // Erase sets all bits; a program pass clears bits, never sets them
  always @(posedge clk) begin
    if (erase_go) begin
      nv_config_word <= CWD_ERASED;
    end else if (prog_go) begin
      nv_config_word <= nv_config_word & prog_word;
    end
  end
endmodule // cwd_programmer_model

//--- cwd_config_word_decoder_tb_top.sv
// Purpose: Self-checking bench for the configuration word decoder
// Assumes: Inputs change at the falling edge, outputs read one falling edge later
// Notes: Each table word is programmed, captured across a reset, decoded and read back
`timescale 1ns/10ps
module cwd_config_word_decoder_tb_top;
  import cwd_pkg::*;
  logic clk = 1'b0; // Bench clock, toggled by one process only
  logic rst_b, prog_mode, cfg_rd, por_event, wake_event, erase_go, prog_go; // Bench-driven controls
  logic [13:0] nv_config_word, cfg_addr, prog_word, cfg_rdata;
  logic cfg_rvalid, settings_valid, flash_protect_on, flash_protect_unsupported, flash_write_enable;
  logic data_protect_on, debugger_enable, debug_pins_io, prog_pin_is_pgm, hv_prog_required;
  logic brownout_reset_enable, power_up_delay_on, watchdog_enable, ext_clock_allowed, osc_startup_req;
  logic [3:0] osc_mode;
  logic [10:0] osc_startup_cycles;
  int fails, samples_checked;
  // Words chosen so every oscillator code and both protect kinds appear
  logic [13:0] words [5] = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555, 14'h2fff};
  ////////////////////////////////////////////////////////////////////////
  cwd_programmer_model u_prog (.clk(clk), .erase_go(erase_go), .prog_go(prog_go), .prog_word(prog_word),
    .nv_config_word(nv_config_word));
  cwd_config_word_decoder u_dut (.clk(clk), .rst_b(rst_b), .nv_config_word(nv_config_word),
    .prog_mode(prog_mode), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .por_event(por_event),
    .wake_event(wake_event), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .settings_valid(settings_valid),
    .flash_protect_on(flash_protect_on), .flash_protect_unsupported(flash_protect_unsupported),
    .flash_write_enable(flash_write_enable), .data_protect_on(data_protect_on),
    .debugger_enable(debugger_enable), .debug_pins_io(debug_pins_io), .prog_pin_is_pgm(prog_pin_is_pgm),
    .hv_prog_required(hv_prog_required), .brownout_reset_enable(brownout_reset_enable),
    .power_up_delay_on(power_up_delay_on), .watchdog_enable(watchdog_enable), .osc_mode(osc_mode),
    .ext_clock_allowed(ext_clock_allowed), .osc_startup_req(osc_startup_req),
    .osc_startup_cycles(osc_startup_cycles));
  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Compare with case inequality so unknowns never match
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Report counts and end the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Erase, then program the word into the model
  task automatic load(input logic [13:0] w);
    @(negedge clk) erase_go = 1'b1;
    @(negedge clk) erase_go = 1'b0;
    prog_word = w;
    prog_go = 1'b1;
    @(negedge clk) prog_go = 1'b0;
  endtask
  // Reset for 5 cycles with a power-on event pending, then let capture land
  task automatic restart();
    @(negedge clk) rst_b = 1'b0;
    por_event = 1'b1;
    repeat (5) @(negedge clk);
    check(14'(settings_valid), 14'h0000);
    check(14'(osc_mode), 14'h0008);
    check(14'(osc_startup_req), 14'h0000);
    por_event = 1'b0;
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check(14'(settings_valid), 14'h0001);
  endtask
  // Expected decode worked out from the word itself
  task automatic chk_word(input logic [13:0] w);
    check(14'(flash_protect_on), 14'(!(w[13:12] == 2'b11 && w[5:4] == 2'b11)));
    check(14'(flash_protect_unsupported), 14'(w[13:12] != w[5:4] || w[13] != w[12]));
    check(14'(flash_write_enable), 14'(w[9]));
    check(14'(data_protect_on), 14'(!w[8]));
    check(14'(debug_pins_io), 14'(w[11]));
    check(14'(debugger_enable), 14'(!w[11]));
    check(14'(prog_pin_is_pgm), 14'(w[7]));
    check(14'(hv_prog_required), 14'(!w[7]));
    check(14'(brownout_reset_enable), 14'(w[6]));
    check(14'(power_up_delay_on), 14'(!w[3] || w[6]));
    check(14'(watchdog_enable), 14'(w[2]));
    check(14'(osc_mode), 14'h0001 << w[1:0]);
    check(14'(ext_clock_allowed), 14'(w[1:0] != 2'b11));
  endtask
  // One read cycle; data only judged when an answer is due
  task automatic rd(input logic [13:0] a, input logic pm, input logic ev, input logic [13:0] d);
    @(negedge clk) cfg_rd = 1'b1;
    prog_mode = pm;
    cfg_addr = a;
    @(negedge clk) cfg_rd = 1'b0;
    check(14'(cfg_rvalid), 14'(ev));
    if (ev) begin
      check(cfg_rdata, d);
    end
  endtask
  // One-cycle event, request expected on the following cycle
  task automatic evt(input logic p, input logic wk, input logic exp);
    @(negedge clk) por_event = p;
    wake_event = wk;
    @(negedge clk) por_event = 1'b0;
    wake_event = 1'b0;
    check(14'(osc_startup_req), 14'(exp));
    check(14'(osc_startup_cycles), exp ? 14'h0400 : 14'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence over the word table
  initial begin
    rst_b = 1'b0;
    {prog_mode, cfg_rd, por_event, wake_event, erase_go, prog_go} = 6'h00;
    cfg_addr = 14'h0000;
    prog_word = 14'h3fff;
    fails = 0;
    samples_checked = 0;
    // Opening reset; the array powers up erased, so the erased decode must show
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check(14'(settings_valid), 14'h0001);
    chk_word(14'h3fff);
    $display("test erased word done");
    for (int i = 0; i < 5; i++) begin
      load(words[i]);
      restart();
      chk_word(words[i]);
      rd(14'h2007, 1'b1, 1'b1, words[i] | 14'h0400);
      rd(14'h2001, 1'b1, 1'b1, 14'h0000);
      rd(14'h1fff, 1'b1, 1'b0, 14'h0000);
      rd(14'h2007, 1'b0, 1'b0, 14'h0000);
      evt(1'b1, 1'b0, words[i][1:0] != 2'b11);
      evt(1'b0, 1'b1, words[i][1:0] != 2'b11);
      evt(1'b0, 1'b0, 1'b0);
      load(~words[i]);
      chk_word(words[i]);
      $display("test word %h done", words[i]);
    end
    give_verdict();
  end
  // Run limit so a hang still reaches the verdict
  initial begin
    #500000;
    fails++;
    $display("BAD t=%0t run limit reached", $time);
    give_verdict();
  end
endmodule // cwd_config_word_decoder_tb_top
